// ---- gsmi_params.svh ----
// Offsets, bit positions, reset values and masks of the group SMI routing block.
`ifndef GSMI_PARAMS_SVH
`define GSMI_PARAMS_SVH

// Register indices; the APB byte address is four times the index.
`define GSMI_IDX_ROUTE 8'h17
`define GSMI_IDX_EN3   8'h18
`define GSMI_IDX_EN4   8'h19
`define GSMI_IDX_STAT  8'h1a
`define GSMI_IDX_MASK  8'h1b
`define GSMI_IDX_LIVE  8'h1c

// Bit positions inside the routing control byte.
`define GSMI_RT_MOUSE  0
`define GSMI_RT_KBD    1
`define GSMI_RT_IR     2
`define GSMI_RT_AUX    4
`define GSMI_RT_WAKE   5
`define GSMI_RT_SER    6
`define GSMI_RT_PIN    7

// Bit positions of the sticky status and mask registers.
`define GSMI_ST_GROUP  0
`define GSMI_ST_BUSERR 1

// Reset value of every enable, routing, status and mask register.
`define GSMI_RST_BYTE  8'h00

// Writable bits: bit 3 of the routing and gpio enable bytes is reserved.
`define GSMI_ROUTE_WMASK 8'hf7
`define GSMI_EN3_WMASK   8'hf7
`define GSMI_STAT_WMASK  8'h03

`endif

// ---- gsmi_pkg.sv ----
// Types shared by the group SMI routing block.
package gsmi_pkg;
    // One byte of register contents.
    typedef logic [7:0] gsmi_byte_t;

    // APB slave phase, one-hot.
    typedef enum logic [2:0] {
        GSMI_IDLE = 3'b001,
        GSMI_WAIT = 3'b010,
        GSMI_DONE = 3'b100
    } gsmi_apb_st_t;
endpackage

// ---- gsmi_sticky.sv ----
// Sticky status byte: hardware sets bits, software clears them by writing ones.
`timescale 1ns/10ps
module gsmi_sticky (
    input  wire logic             mclk,
    input  wire logic             resetn,
    input  wire gsmi_pkg::gsmi_byte_t setBits,
    input  wire gsmi_pkg::gsmi_byte_t clrBits,
    output gsmi_pkg::gsmi_byte_t  status_r
);
`include "gsmi_params.svh"

    // A set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            status_r <= `GSMI_RST_BYTE;
        end else begin
            status_r <= (status_r & ~clrBits) | setBits;
        end
    end
endmodule

// ---- gsmi_route.sv ----
// Group SMI enable gating and routing to pin, serial IRQ and wake logic, with APB registers.
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
//
// Behaviour
// - Routing bit 4 enables aux port-line source
// - Routing bit 5 forwards group into wake
// - Routing bit 6 places group on serial IRQ
// - Routing bit 7 drives active-low pin
// - Gpio enable byte maps pins, bit 3 reserved
// - Enable one admits source, zero blocks
// - Misc enable byte gates more sources, RW
// - Enables reset to zero on standby reset
// - Routing bits 0-2 enable mouse, keyboard, infrared
module gsmi_route (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        mouseIrq,
    input  wire logic        keyboardIrq,
    input  wire logic        infraredIrq,
    input  wire logic        auxPortIrq,
    input  wire logic [7:0]  gpioIrq,
    input  wire logic [7:0]  miscIrq,
    output logic             smiOutputPinN,
    output logic             serialIrqSmi,
    output logic             wakeEventSmi,
    output logic             groupMgmtIrqN,
    output logic             irq
);
`include "gsmi_params.svh"

    // True when a byte address selects the register with the given index.
    function automatic logic hitIdx(input logic [9:0] a, input logic [7:0] idx);
        hitIdx = (a == {idx, 2'b00});
    endfunction

    gsmi_pkg::gsmi_apb_st_t st_r;        // APB slave phase.
    gsmi_pkg::gsmi_apb_st_t st_nxt;      // Next APB slave phase.
    gsmi_pkg::gsmi_byte_t   route_r;     // Routing control byte.
    gsmi_pkg::gsmi_byte_t   en3_r;       // Gpio pin enable byte.
    gsmi_pkg::gsmi_byte_t   en4_r;       // Misc source enable byte.
    gsmi_pkg::gsmi_byte_t   mask_r;      // Interrupt mask byte.
    gsmi_pkg::gsmi_byte_t   status;      // Sticky status byte.
    gsmi_pkg::gsmi_byte_t   statSet;     // Status set pulses.
    gsmi_pkg::gsmi_byte_t   statClr;     // Status clear pulses.
    gsmi_pkg::gsmi_byte_t   liveVal;     // Live state seen by software.
    gsmi_pkg::gsmi_byte_t   rdByte;      // Read multiplexer output.
    logic [31:0]            prdata_r;    // Registered read data.
    logic                   pready_r;    // Registered ready.
    logic                   pslverr_r;   // Registered error.
    logic                   groupAct_r;  // Registered combined group level.
    logic                   groupActN_r; // Registered combined group level, active low.
    logic                   pinN_r;      // Registered pin level, active low.
    logic                   serial_r;    // Registered serial IRQ request.
    logic                   wake_r;      // Registered wake request.
    logic                   irq_r;       // Registered interrupt output.

    // Address decode of the mapped registers.
    wire selRoute = hitIdx(paddr, `GSMI_IDX_ROUTE);
    wire selEn3   = hitIdx(paddr, `GSMI_IDX_EN3);
    wire selEn4   = hitIdx(paddr, `GSMI_IDX_EN4);
    wire selStat  = hitIdx(paddr, `GSMI_IDX_STAT);
    wire selMask  = hitIdx(paddr, `GSMI_IDX_MASK);
    wire selLive  = hitIdx(paddr, `GSMI_IDX_LIVE);
    wire mapped   = selRoute | selEn3 | selEn4 | selStat | selMask | selLive;

    // The access phase completes at this edge; writes take effect only here.
    wire accDone  = (st_r == gsmi_pkg::GSMI_DONE) & psel & penable;
    wire wrDone   = accDone & pwrite;
    wire errDone  = accDone & ~mapped;

    // Each source is admitted by a one and blocked by a zero.
    wire routeSrc = (route_r[`GSMI_RT_MOUSE] & mouseIrq)
                  | (route_r[`GSMI_RT_KBD]   & keyboardIrq)
                  | (route_r[`GSMI_RT_IR]    & infraredIrq)
                  | (route_r[`GSMI_RT_AUX]   & auxPortIrq);
    // Bit 3 of the gpio byte never holds a one, so that input is ignored.
    wire gpioSrc  = |(en3_r & gpioIrq);
    wire miscSrc  = |(en4_r & miscIrq);
    // Combined group level: any enabled active source.
    wire groupNxt = routeSrc | gpioSrc | miscSrc;

    // Status events: a new group assertion and an unmapped access.
    assign statSet = {6'h00, errDone, groupNxt & ~groupAct_r};
    assign statClr = (wrDone & selStat) ? (pwdata[7:0] & `GSMI_STAT_WMASK) : 8'h00;
    assign liveVal = {4'h0, wake_r, serial_r, ~pinN_r, groupAct_r};

    // Read multiplexer; unmapped addresses read as zero.
    assign rdByte = selRoute ? route_r :
                    selEn3   ? en3_r   :
                    selEn4   ? en4_r   :
                    selStat  ? status  :
                    selMask  ? mask_r  :
                    selLive  ? liveVal : 8'h00;

    // APB phase sequencing: one wait cycle, then ready for one cycle.
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            gsmi_pkg::GSMI_IDLE: begin
                if (psel && !penable) begin
                    st_nxt = gsmi_pkg::GSMI_WAIT;
                end
            end
            gsmi_pkg::GSMI_WAIT: begin
                st_nxt = gsmi_pkg::GSMI_DONE;
            end
            gsmi_pkg::GSMI_DONE: begin
                st_nxt = gsmi_pkg::GSMI_IDLE;
            end
            default: begin
                st_nxt = gsmi_pkg::GSMI_IDLE;
            end
        endcase
    end

    // Bus answer registers: data, ready and error are loaded with the ready edge.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_r      <= gsmi_pkg::GSMI_IDLE;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            st_r      <= st_nxt;
            pready_r  <= (st_nxt == gsmi_pkg::GSMI_DONE);
            pslverr_r <= (st_nxt == gsmi_pkg::GSMI_DONE) & ~mapped;
            prdata_r  <= {24'h00_0000, rdByte};
        end
    end

    // Enable and mask registers; all start disabled after the standby reset.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            route_r <= `GSMI_RST_BYTE;
            en3_r   <= `GSMI_RST_BYTE;
            en4_r   <= `GSMI_RST_BYTE;
            mask_r  <= `GSMI_RST_BYTE;
        end else if (wrDone) begin
            if (selRoute) begin
                route_r <= pwdata[7:0] & `GSMI_ROUTE_WMASK;
            end else if (selEn3) begin
                en3_r <= pwdata[7:0] & `GSMI_EN3_WMASK;
            end else if (selEn4) begin
                en4_r <= pwdata[7:0];
            end else if (selMask) begin
                mask_r <= pwdata[7:0] & `GSMI_STAT_WMASK;
            end
        end
    end

    // Sticky event status with write-one-to-clear.
    gsmi_sticky u_status (
        .mclk     (mclk),
        .resetn   (resetn),
        .setBits  (statSet),
        .clrBits  (statClr),
        .status_r (status)
    );

    // Route the group level to the pin, the serial stream and the wake logic.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            groupAct_r <= 1'b0;
            groupActN_r <= 1'b1;
            pinN_r     <= 1'b1;
            serial_r   <= 1'b0;
            wake_r     <= 1'b0;
            irq_r      <= 1'b0;
        end else begin
            groupAct_r <= groupNxt;
            groupActN_r <= ~groupNxt;
            wake_r     <= groupNxt & route_r[`GSMI_RT_WAKE];
            serial_r   <= groupNxt & route_r[`GSMI_RT_SER];
            pinN_r     <= ~(groupNxt & route_r[`GSMI_RT_PIN]);
            irq_r      <= |(status & mask_r);
        end
    end

    // Every output comes straight from a flip-flop.
    assign prdata        = prdata_r;
    assign pready        = pready_r;
    assign pslverr       = pslverr_r;
    assign groupMgmtIrqN = groupActN_r;
    assign smiOutputPinN = pinN_r;
    assign serialIrqSmi  = serial_r;
    assign wakeEventSmi  = wake_r;
    assign irq           = irq_r;

    // A completed write to the misc enable register.
    sequence s_en4Write;
        wrDone && selEn4;
    endsequence

    // Any source admitted by its enable.
    sequence s_anyAdmitted;
        routeSrc || gpioSrc || miscSrc;
    endsequence

    // Setup phase of an APB transfer seen while the slave is idle.
    sequence s_apbSetup;
        psel && !penable && (st_r == gsmi_pkg::GSMI_IDLE);
    endsequence

    // One wait cycle, then ready for exactly one cycle.
    sequence s_apbAnswer;
        !pready ##1 pready ##1 !pready;
    endsequence

    // The checks below watch the registered outputs one edge after their cause; a_gpio_rsvd, a_reset_zero and a_group_pair check within one cycle.
    // A route bit that is clear must keep its path quiet even with sources active,
    // since the host would otherwise take a request that software never enabled.

    a_aux_gate: assert property (@(posedge mclk) disable iff (!resetn)
        (route_r[`GSMI_RT_AUX] && auxPortIrq) |=> groupAct_r)
        else $error("Enabled aux source did not raise the group level.");

    a_wake_route: assert property (@(posedge mclk) disable iff (!resetn)
        (route_r[`GSMI_RT_WAKE] && (routeSrc || gpioSrc || miscSrc)) |=> wake_r)
        else $error("Wake forward missing with routing bit and source set.");

    a_wake_block: assert property (@(posedge mclk) disable iff (!resetn)
        !route_r[`GSMI_RT_WAKE] |=> !wake_r)
        else $error("Wake forward raised with its routing bit clear.");

    a_serial_route: assert property (@(posedge mclk) disable iff (!resetn)
        !route_r[`GSMI_RT_SER] |=> !serial_r)
        else $error("Serial request raised with its routing bit clear.");

    a_pin_route: assert property (@(posedge mclk) disable iff (!resetn)
        !pinN_r |-> $past(route_r[`GSMI_RT_PIN]) && groupAct_r)
        else $error("Pin went low without routing bit and group level.");

    a_gpio_rsvd: assert property (@(posedge mclk) disable iff (!resetn)
        en3_r[3] == 1'b0 && route_r[3] == 1'b0)
        else $error("Reserved enable bit holds a one.");

    a_all_blocked: assert property (@(posedge mclk) disable iff (!resetn)
        (route_r[4:0] == 5'h00 && en3_r == 8'h00 && en4_r == 8'h00) |=> !groupAct_r)
        else $error("Group level raised with every enable clear.");

    a_en4_write: assert property (@(posedge mclk) disable iff (!resetn)
        s_en4Write |=> en4_r == $past(pwdata[7:0]))
        else $error("Misc enable write was not stored.");

    a_reset_zero: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(resetn) |-> (route_r == 8'h00 && en3_r == 8'h00 && en4_r == 8'h00))
        else $error("Enable bytes not zero after reset.");

    a_mouse_gate: assert property (@(posedge mclk) disable iff (!resetn)
        (route_r[`GSMI_RT_MOUSE] && mouseIrq) |=> groupAct_r && !groupMgmtIrqN)
        else $error("Enabled mouse source did not raise the group output.");

    a_group_or: assert property (@(posedge mclk) disable iff (!resetn)
        s_anyAdmitted |=> groupAct_r ##0 !groupMgmtIrqN)
        else $error("Admitted source did not raise the group output.");

    a_group_none: assert property (@(posedge mclk) disable iff (!resetn)
        !(routeSrc || gpioSrc || miscSrc) |=> !groupAct_r)
        else $error("Group output raised with no admitted source.");

    // An admitted source with the serial route set must reach the serial stream.
    a_serial_fwd: assert property (@(posedge mclk) disable iff (!resetn)
        (route_r[`GSMI_RT_SER] && (routeSrc || gpioSrc || miscSrc)) |=> serialIrqSmi)
        else $error("Serial request missing with routing bit and source set.");

    // The pin stays inactive, that is high, while its routing bit is clear.
    a_pin_block: assert property (@(posedge mclk) disable iff (!resetn)
        !route_r[`GSMI_RT_PIN] |=> smiOutputPinN)
        else $error("Pin went low with its routing bit clear.");

    // The top gpio enable bit admits its pin to the group output.
    a_gpio_gate: assert property (@(posedge mclk) disable iff (!resetn)
        (en3_r[7] && gpioIrq[7]) |=> !groupMgmtIrqN)
        else $error("Enabled gpio source did not raise the group output.");

    // A misc enable bit admits its source to the group output.
    a_misc_gate: assert property (@(posedge mclk) disable iff (!resetn)
        (en4_r[0] && miscIrq[0]) |=> !groupMgmtIrqN)
        else $error("Enabled misc source did not raise the group output.");

    // The active-low group flop and the internal level never disagree.
    a_group_pair: assert property (@(posedge mclk) disable iff (!resetn)
        groupMgmtIrqN != groupAct_r)
        else $error("Group output and group level disagree.");

    // Every transfer gets one wait cycle and a single-cycle ready.
    a_apb_answer: assert property (@(posedge mclk) disable iff (!resetn)
        s_apbSetup |=> s_apbAnswer)
        else $error("Bus answer did not follow the one-wait-cycle pattern.");

    // A set status bit under an open mask raises the interrupt line.
    a_irq_level: assert property (@(posedge mclk) disable iff (!resetn)
        (|(status & mask_r)) |=> irq)
        else $error("Unmasked status bit did not raise the interrupt.");
endmodule

// ---- gsmi_host.sv ----
// Host chipset stand-in that records which group SMI routes reached it.
`timescale 1ns/10ps
module gsmi_host (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       smiOutputPinN,
    input  wire logic       serialIrqSmi,
    input  wire logic       wakeEventSmi,
    output logic      [2:0] seen
);
    // Sticky record of wake, serial and pin paths seen active since reset.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            seen <= 3'b000;
        end else begin
            seen <= seen | {wakeEventSmi, serialIrqSmi, !smiOutputPinN};
        end
    end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the group SMI routing block.
`timescale 1ns/10ps
`include "gsmi_params.svh"
module testbench;
    logic        mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [9:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic        pready, pslverr, smiOutputPinN, serialIrqSmi, wakeEventSmi;
    logic        mouseIrq = 0, keyboardIrq = 0, infraredIrq = 0, auxPortIrq = 0;
    logic [7:0]  gpioIrq = 0, miscIrq = 0, rd;
    logic        groupMgmtIrqN, irq, er, g;
    logic [23:0] rdHi;
    logic [2:0]  hostSeen;
    logic [7:0]  rt, e3, e4;
    int          failures = 0, num_checks = 0;
    // Clock of 5 ns period.
    always #2.5 mclk = ~mclk;
    gsmi_route i_gsmi_route (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mouseIrq(mouseIrq), .keyboardIrq(keyboardIrq),
        .infraredIrq(infraredIrq), .auxPortIrq(auxPortIrq), .gpioIrq(gpioIrq),
        .miscIrq(miscIrq), .smiOutputPinN(smiOutputPinN), .serialIrqSmi(serialIrqSmi),
        .wakeEventSmi(wakeEventSmi), .groupMgmtIrqN(groupMgmtIrqN), .irq(irq));
    gsmi_host i_gsmi_host (.mclk(mclk), .resetn(resetn), .smiOutputPinN(smiOutputPinN),
        .serialIrqSmi(serialIrqSmi), .wakeEventSmi(wakeEventSmi), .seen(hostSeen));
    // Prints the verdict and ends the run.
    task print_verdict;
        if (failures == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Compares one observed value with its expectation.
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for pready under a bounded count.
    task apb(input bit wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {8'($urandom_range(255, 0)), 16'h0000, wd};
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            print_verdict();
        end else begin
            rd      = prdata[7:0];
            rdHi    = prdata[31:8];
            er      = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // Reads one register and compares data and error flag.
    task rdchk(input logic [7:0] idx, input logic [7:0] exp);
        apb(0, idx, 8'h00);
        chk(rd, exp);
        chk(er, 1'b0);
        chk(rdHi, 24'h00_0000);
    endtask
    // Lets outputs settle, then samples the level interrupt.
    task irqchk(input logic exp);
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk(irq, exp);
    endtask
    // Main sequence.
    initial begin
        void'($urandom(342));
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        rdchk(`GSMI_IDX_ROUTE, 8'h00);
        rdchk(`GSMI_IDX_EN3, 8'h00);
        rdchk(`GSMI_IDX_EN4, 8'h00);
        rdchk(`GSMI_IDX_STAT, 8'h00);
        rdchk(`GSMI_IDX_MASK, 8'h00);
        apb(1, `GSMI_IDX_ROUTE, 8'hff);
        apb(1, `GSMI_IDX_EN3, 8'hff);
        apb(1, `GSMI_IDX_EN4, 8'hff);
        rdchk(`GSMI_IDX_ROUTE, 8'hf7);
        rdchk(`GSMI_IDX_EN3, 8'hf7);
        rdchk(`GSMI_IDX_EN4, 8'hff);
        // Unmapped address: error, zero data, bus error status bit.
        apb(0, 8'h30, 8'h00);
        chk({er, rd}, 9'h100);
        rdchk(`GSMI_IDX_STAT, 8'h02);
        irqchk(1'b0);
        apb(1, `GSMI_IDX_MASK, 8'h02);
        irqchk(1'b1);
        apb(1, `GSMI_IDX_MASK, 8'h00);
        irqchk(1'b0);
        apb(1, `GSMI_IDX_MASK, 8'h02);
        apb(1, `GSMI_IDX_STAT, 8'h02);
        irqchk(1'b0);
        rdchk(`GSMI_IDX_STAT, 8'h00);
        // Random enables, routes and sources against the bench model.
        for (int i = 0; i < 40; i++) begin
            rt = 8'($urandom);
            e3 = 8'($urandom);
            e4 = (i % 3 == 0) ? 8'h00 : 8'($urandom);
            apb(1, `GSMI_IDX_ROUTE, rt);
            apb(1, `GSMI_IDX_EN3, e3);
            apb(1, `GSMI_IDX_EN4, e4);
            @(posedge mclk);
            {mouseIrq, keyboardIrq, infraredIrq, auxPortIrq} <= 4'($urandom);
            gpioIrq <= 8'($urandom);
            miscIrq <= 8'($urandom);
            repeat (3) @(posedge mclk);
            @(negedge mclk);
            g = (mouseIrq & rt[0]) | (keyboardIrq & rt[1]) | (infraredIrq & rt[2])
                | (auxPortIrq & rt[4]) | (|(gpioIrq & e3 & 8'hf7)) | (|(miscIrq & e4));
            chk(groupMgmtIrqN, !g);
            chk(smiOutputPinN, !(g & rt[7]));
            chk(serialIrqSmi, g & rt[6]);
            chk(wakeEventSmi, g & rt[5]);
            rdchk(`GSMI_IDX_LIVE, {4'h0, g & rt[5], g & rt[6], g & rt[7], g});
        end
        // Quiet sources, clear status, then a group rise sets status bit 0.
        @(posedge mclk);
        {mouseIrq, keyboardIrq, infraredIrq, auxPortIrq} <= 4'h0;
        gpioIrq <= 8'h00;
        miscIrq <= 8'h00;
        apb(1, `GSMI_IDX_STAT, 8'h03);
        rdchk(`GSMI_IDX_STAT, 8'h00);
        apb(1, `GSMI_IDX_MASK, 8'h01);
        apb(1, `GSMI_IDX_ROUTE, 8'h81);
        @(posedge mclk);
        mouseIrq <= 1'b1;
        irqchk(1'b1);
        chk(smiOutputPinN, 1'b0);
        rdchk(`GSMI_IDX_STAT, 8'h01);
        // Clearing while the source holds must not set the bit again.
        apb(1, `GSMI_IDX_STAT, 8'h01);
        irqchk(1'b0);
        chk(hostSeen, 3'b111);
        // Reset in mid-run: every enable and route returns to zero.
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(smiOutputPinN, 1'b1);
        resetn <= 1'b1;
        rdchk(`GSMI_IDX_ROUTE, 8'h00);
        rdchk(`GSMI_IDX_EN3, 8'h00);
        rdchk(`GSMI_IDX_EN4, 8'h00);
        chk(groupMgmtIrqN, 1'b1);
        print_verdict();
    end
endmodule
